// [core/lfio_executor.sv]
/*
 Executor for zone output inhibit, temporary scan end, suspend trap and
 immediate masked input/output operations of a scanned ladder controller.
 Assumes an instruction sequencer presents one operation per cycle with its
 rung condition, and takes back the scan-restart requests made here.
*/
// Functional notes
// - Zone opener true: rungs in zone follow their own condition.
// - Zone opener false: non-retentive outputs in zone forced reset.
// - Rungs in an inhibited zone are still scanned, not skipped.
// - Non-retentive output resets whenever its rung is false.
// - Jump into a zone makes the zone active from the target.
// - Timers in a disabled zone stop operating.
// - True temporary end: stop file, update I/O, restart file 2 rung 0.
// - False temporary end: scanning continues to next end.
// - True temporary end abandons all subroutine nesting levels at once.
// - Temporary end in files 3, 4 or 5 raises a fault.
// - Suspend: idle mode, identifier to code word, all outputs off.
// - Immediate input copies masked word into image; later rungs see it.
// - Mask bit 1 passes source bit, 0 leaves destination unchanged.
// - Input bits existing depend on unit size; second word sets four bits, large unit only.
// - Immediate output copies masked image to outputs, scan resumes.
// - Only outputs 0-5 or 0-11 exist; other bits have no output.
`timescale 1ns/1ns
module lfio_executor
    import lfio_pkg::*;
(
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        bigUnit,
    input  wire logic                        opValid,
    input  wire lfio_pkg::lfio_op_t          opCode,
    input  wire logic                        rungTrue,
    input  wire logic                        opSelSecond,
    input  wire logic [lfio_pkg::WORD_W-1:0] opMask,
    input  wire logic [lfio_pkg::WORD_W-1:0] opSuspendId,
    input  wire logic [lfio_pkg::WORD_W-1:0] opBitSel,
    input  wire logic [lfio_pkg::FILE_W-1:0] curFile,
    input  wire logic                        ioUpdateDone,
    input  wire logic [lfio_pkg::WORD_W-1:0] firstInputWord,
    input  wire logic [lfio_pkg::WORD_W-1:0] secondInputWord,
    output logic      [lfio_pkg::WORD_W-1:0] inImage0_r,
    output logic      [lfio_pkg::WORD_W-1:0] inImage1_r,
    output logic      [lfio_pkg::WORD_W-1:0] outImage_r,
    output logic      [lfio_pkg::WORD_W-1:0] firstOutputWord_r,
    output logic      [lfio_pkg::WORD_W-1:0] suspendCodeWord_r,
    output logic                             zoneInhibit_r,
    output logic                             timerRun_r,
    output logic                             scanRestart_r,
    output logic      [lfio_pkg::FILE_W-1:0] restartFile_r,
    output logic      [lfio_pkg::RUNG_W-1:0] restartRung_r,
    output logic                             ioUpdateReq_r,
    output logic                             suspended_r,
    output logic                             fault_r,
    output logic      [lfio_pkg::NEST_W-1:0] nestDepth_r
);
    // ===================================================
    // State
    typedef struct packed {
        lfio_state_t         state;
        logic                inZone;
        logic                zoneInhibit;
        logic                timerRun;
        logic                scanRestart;
        logic [FILE_W-1:0]   restartFile;
        logic [RUNG_W-1:0]   restartRung;
        logic                ioUpdateReq;
        logic [NEST_W-1:0]   nestDepth;
        logic                suspended;
        logic                fault;
        logic [WORD_W-1:0]   inImage0;
        logic [WORD_W-1:0]   inImage1;
        logic [WORD_W-1:0]   outImage;
        logic [WORD_W-1:0]   outPhys;
        logic [WORD_W-1:0]   suspendCode;
    } lfio_st_t;

    lfio_st_t st_r;
    lfio_st_t st_nxt;
    default clocking cbSys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    logic [WORD_W-1:0] inValid;
    logic [WORD_W-1:0] outValid;
    logic [WORD_W-1:0] inSrc;
    logic [WORD_W-1:0] inDst;
    logic [WORD_W-1:0] inMerged;
    logic [WORD_W-1:0] outMerged;
    logic              effRung;
    logic              isRunOp;
    logic              isSysFile;

    // ===================================================
    // Masked transfer paths
    always_comb begin
        if (opSelSecond) begin
            inValid = bigUnit ? IN1_VALID_32 : WORD_ZERO;
            inSrc   = secondInputWord;
            inDst   = st_r.inImage1;
        end else begin
            inValid = bigUnit ? IN0_VALID_32 : IN0_VALID_16;
            inSrc   = firstInputWord;
            inDst   = st_r.inImage0;
        end
        outValid = bigUnit ? OUT_VALID_32 : OUT_VALID_16;
    end

    lfio_mask_merge u_in_merge (
        .srcWord    (inSrc),
        .dstWord    (inDst),
        .maskWord   (opMask),
        .validBits  (inValid),
        .mergedWord (inMerged)
    );

    lfio_mask_merge u_out_merge (
        .srcWord    (st_r.outImage),
        .dstWord    (st_r.outPhys),
        .maskWord   (opMask),
        .validBits  (outValid),
        .mergedWord (outMerged)
    );

    // ===================================================
    // Operation decode
    always_comb begin
        isRunOp   = opValid && (st_r.state == LFIO_ST_RUN);
        // Inhibited zone overrides the rung's own condition
        effRung   = rungTrue && !st_r.zoneInhibit;
        isSysFile = (curFile == FAULT_FILE) || (curFile == COUNTER_FILE) ||
                    (curFile == TIMED_FILE);
        st_nxt             = st_r;
        st_nxt.scanRestart = 1'b0;
        case (st_r.state)
            LFIO_ST_RUN: begin
                if (isRunOp) begin
                    case (opCode)
                        LFIO_OP_ZONE: begin
                            // Opener rung condition sets the inhibit, closer is
                            // unconditional; toggle opens or closes the single zone level
                            if (!st_r.inZone) begin
                                st_nxt.inZone      = 1'b1;
                                st_nxt.zoneInhibit = !rungTrue;
                            end else begin
                                st_nxt.inZone      = 1'b0;
                                st_nxt.zoneInhibit = 1'b0;
                            end
                        end
                        LFIO_OP_JUMP_IN: begin
                            st_nxt.inZone      = 1'b1;
                            st_nxt.zoneInhibit = 1'b0;
                        end
                        LFIO_OP_COIL: begin
                            // Still scanned: the coil bit is written
                            // from the inhibited condition
                            if (effRung) begin
                                st_nxt.outImage =
                                    st_r.outImage | opBitSel;
                            end else begin
                                st_nxt.outImage =
                                    st_r.outImage & ~opBitSel;
                            end
                        end
                        LFIO_OP_TIMER: begin
                            st_nxt.timerRun = effRung;
                        end
                        LFIO_OP_CALL: begin
                            if (rungTrue) begin
                                st_nxt.nestDepth = st_r.nestDepth + NEST_ONE;
                            end
                        end
                        LFIO_OP_RETURN: begin
                            if (rungTrue && st_r.nestDepth != NEST_ZERO) begin
                                st_nxt.nestDepth = st_r.nestDepth - NEST_ONE;
                            end
                        end
                        LFIO_OP_TMP_END: begin
                            if (isSysFile) begin
                                st_nxt.state = LFIO_ST_FAULT;
                                st_nxt.fault = 1'b1;
                            end else if (rungTrue) begin
                                st_nxt.nestDepth   = NEST_ZERO;
                                st_nxt.inZone      = 1'b0;
                                st_nxt.zoneInhibit = 1'b0;
                                st_nxt.ioUpdateReq = 1'b1;
                                st_nxt.state       = LFIO_ST_IOUPD;
                            end
                            // False rung: nothing, the scan goes on
                        end
                        LFIO_OP_FINAL_END: begin
                            st_nxt.nestDepth   = NEST_ZERO;
                            st_nxt.inZone      = 1'b0;
                            st_nxt.zoneInhibit = 1'b0;
                            st_nxt.ioUpdateReq = 1'b1;
                            st_nxt.state       = LFIO_ST_IOUPD;
                        end
                        LFIO_OP_SUSPEND: begin
                            // Identifier kept as raw signed 16 bits
                            st_nxt.suspendCode = opSuspendId;
                            st_nxt.outPhys     = WORD_ZERO;
                            st_nxt.state       = LFIO_ST_SUSPEND;
                            st_nxt.suspended   = 1'b1;
                        end
                        LFIO_OP_IMM_IN: begin
                            if (effRung) begin
                                // Mask is a resolved value here
                                if (opSelSecond) begin
                                    st_nxt.inImage1 = inMerged;
                                end else begin
                                    st_nxt.inImage0 = inMerged;
                                end
                            end
                        end
                        LFIO_OP_IMM_OUT: begin
                            if (effRung) begin
                                st_nxt.outPhys = outMerged;
                            end
                        end
                        default: begin
                            st_nxt.state = st_r.state;
                        end
                    endcase
                end
            end
            LFIO_ST_IOUPD: begin
                // Normal I/O scan waits on the sequencer's handshake
                if (ioUpdateDone) begin
                    st_nxt.ioUpdateReq = 1'b0;
                    st_nxt.outPhys     = st_r.outImage & outValid;
                    st_nxt.inImage0    = firstInputWord &
                        (bigUnit ? IN0_VALID_32 : IN0_VALID_16);
                    st_nxt.inImage1    = secondInputWord &
                        (bigUnit ? IN1_VALID_32 : WORD_ZERO);
                    st_nxt.scanRestart = 1'b1;
                    st_nxt.restartFile = MAIN_FILE;
                    st_nxt.restartRung = FIRST_RUNG;
                    st_nxt.state       = LFIO_ST_RUN;
                end
            end
            LFIO_ST_SUSPEND: begin
                st_nxt.outPhys = WORD_ZERO;
            end
            LFIO_ST_FAULT: begin
                st_nxt.outPhys = WORD_ZERO;
            end
            default: begin
                st_nxt.state = LFIO_ST_FAULT;
                st_nxt.fault = 1'b1;
            end
        endcase
    end

    // ===================================================
    // Registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r.state       <= LFIO_ST_RUN;
            st_r.inZone      <= 1'b0;
            st_r.zoneInhibit <= 1'b0;
            st_r.timerRun    <= 1'b0;
            st_r.scanRestart <= 1'b0;
            st_r.restartFile <= MAIN_FILE;
            st_r.restartRung <= FIRST_RUNG;
            st_r.ioUpdateReq <= 1'b0;
            st_r.nestDepth   <= NEST_ZERO;
            st_r.suspended   <= 1'b0;
            st_r.fault       <= 1'b0;
            st_r.inImage0    <= WORD_ZERO;
            st_r.inImage1    <= WORD_ZERO;
            st_r.outImage    <= WORD_ZERO;
            st_r.outPhys     <= WORD_ZERO;
            st_r.suspendCode <= WORD_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ===================================================
    // Outputs straight from the state flops
    assign inImage0_r        = st_r.inImage0;
    assign inImage1_r        = st_r.inImage1;
    assign outImage_r        = st_r.outImage;
    assign firstOutputWord_r = st_r.outPhys;
    assign suspendCodeWord_r = st_r.suspendCode;
    assign zoneInhibit_r     = st_r.zoneInhibit;
    assign timerRun_r        = st_r.timerRun;
    assign scanRestart_r     = st_r.scanRestart;
    assign restartFile_r     = st_r.restartFile;
    assign restartRung_r     = st_r.restartRung;
    assign ioUpdateReq_r     = st_r.ioUpdateReq;
    assign suspended_r       = st_r.suspended;
    assign fault_r           = st_r.fault;
    assign nestDepth_r       = st_r.nestDepth;

    // ===================================================
    // Assertions
    a_zone_coil_off: assert property (
        isRunOp && opCode == LFIO_OP_COIL && st_r.zoneInhibit
        |=> (outImage_r & $past(opBitSel)) == WORD_ZERO)
        else $error("inhibited zone coil not reset");
    a_zone_follow: assert property (
        isRunOp && opCode == LFIO_OP_COIL && !st_r.zoneInhibit && rungTrue
        |=> (outImage_r & $past(opBitSel)) == $past(opBitSel))
        else $error("active zone coil not set");
    a_coil_false: assert property (
        isRunOp && opCode == LFIO_OP_COIL && !rungTrue
        |=> (outImage_r & $past(opBitSel)) == WORD_ZERO)
        else $error("false rung coil not reset");
    a_jump_active: assert property (
        isRunOp && opCode == LFIO_OP_JUMP_IN |=> !zoneInhibit_r)
        else $error("jump into zone left it inhibited");
    a_timer_stop: assert property (
        isRunOp && opCode == LFIO_OP_TIMER && st_r.zoneInhibit
        |=> !timerRun_r)
        else $error("timer runs in disabled zone");
    a_tend_restart: assert property (
        isRunOp && opCode == LFIO_OP_TMP_END && rungTrue && !isSysFile
        |=> ioUpdateReq_r && nestDepth_r == NEST_ZERO ##[0:200] scanRestart_r
        && restartFile_r == MAIN_FILE && restartRung_r == FIRST_RUNG)
        else $error("temporary end did not restart main file");
    a_tend_false: assert property (
        isRunOp && opCode == LFIO_OP_TMP_END && !rungTrue && !isSysFile
        |=> !ioUpdateReq_r && !fault_r)
        else $error("false temporary end stopped scan");
    a_tend_fault: assert property (
        isRunOp && opCode == LFIO_OP_TMP_END && isSysFile |=> fault_r)
        else $error("temporary end in system file without fault");
    a_suspend_id: assert property (
        isRunOp && opCode == LFIO_OP_SUSPEND |=> suspended_r
        && suspendCodeWord_r == $past(opSuspendId)
        && firstOutputWord_r == WORD_ZERO)
        else $error("suspend trap incomplete");
    a_imm_in_mask: assert property (
        isRunOp && opCode == LFIO_OP_IMM_IN && effRung && !opSelSecond
        |=> ((inImage0_r ^ $past(st_r.inImage0)) & ~$past(opMask))
        == WORD_ZERO)
        else $error("unmasked input bit changed");
    a_imm_out_mask: assert property (
        isRunOp && opCode == LFIO_OP_IMM_OUT && effRung
        |=> (((firstOutputWord_r ^ $past(firstOutputWord_r))
        & ~$past(opMask)) == WORD_ZERO)
        && (((firstOutputWord_r ^ $past(outImage_r)) & $past(opMask)
        & outValid) == WORD_ZERO))
        else $error("immediate output wrong");
    a_out_phys: assert property (
        (firstOutputWord_r & ~(bigUnit ? OUT_VALID_32 : OUT_VALID_16))
        == WORD_ZERO)
        else $error("nonexistent output driven");

    c_tend: cover property (ioUpdateReq_r ##[1:20] scanRestart_r);
    c_suspend: cover property (suspended_r);
    c_zone_inh: cover property (zoneInhibit_r ##1 !zoneInhibit_r);
    c_imm_in: cover property (isRunOp && opCode == LFIO_OP_IMM_IN && effRung);
endmodule

// [core/lfio_mask_merge.sv]
/*
 Per-bit masked merge of a source word into a destination word, limited to
 the bits that physically exist. Purely combinational.
*/
`timescale 1ns/1ns
module lfio_mask_merge
    import lfio_pkg::*;
(
    input  wire logic [lfio_pkg::WORD_W-1:0] srcWord,
    input  wire logic [lfio_pkg::WORD_W-1:0] dstWord,
    input  wire logic [lfio_pkg::WORD_W-1:0] maskWord,
    input  wire logic [lfio_pkg::WORD_W-1:0] validBits,
    output logic      [lfio_pkg::WORD_W-1:0] mergedWord
);
    // ===================================================
    // Merge, one bit per generate entry
    genvar gi;
    generate
        for (gi = 0; gi < WORD_W; gi++) begin : g_bit
            // Mask 1 on an existing bit passes the source, otherwise the destination is kept
            assign mergedWord[gi] = (maskWord[gi] && validBits[gi]) ?
                                    srcWord[gi] : dstWord[gi];
        end
    endgenerate
endmodule

// [core/lfio_pkg.sv]
/*
 Constants, enums and field layouts for the program-flow and immediate I/O
 executor. Shared by the executor and its masked transfer unit.
*/
package lfio_pkg;
    // ===================================================
    // Operation codes presented on the instruction port
    typedef enum logic [3:0] {
        LFIO_OP_NOP       = 4'b0000,
        LFIO_OP_ZONE      = 4'b0001,
        LFIO_OP_TMP_END   = 4'b0010,
        LFIO_OP_SUSPEND   = 4'b0011,
        LFIO_OP_IMM_IN    = 4'b0100,
        LFIO_OP_IMM_OUT   = 4'b0101,
        LFIO_OP_COIL      = 4'b0110,
        LFIO_OP_TIMER     = 4'b0111,
        LFIO_OP_JUMP_IN   = 4'b1000,
        LFIO_OP_FINAL_END = 4'b1001,
        LFIO_OP_CALL      = 4'b1010,
        LFIO_OP_RETURN    = 4'b1011
    } lfio_op_t;

    // ===================================================
    // Scan states
    typedef enum logic [1:0] {
        LFIO_ST_RUN     = 2'b00,
        LFIO_ST_IOUPD   = 2'b01,
        LFIO_ST_SUSPEND = 2'b10,
        LFIO_ST_FAULT   = 2'b11
    } lfio_state_t;

    // ===================================================
    // Widths and I/O geometry
    localparam int WORD_W      = 16;
    localparam int NEST_W      = 4;
    localparam int FILE_W      = 4;
    localparam int RUNG_W      = 10;
    localparam logic [FILE_W-1:0] MAIN_FILE     = 4'h2;
    localparam logic [FILE_W-1:0] FAULT_FILE    = 4'h3;
    localparam logic [FILE_W-1:0] COUNTER_FILE  = 4'h4;
    localparam logic [FILE_W-1:0] TIMED_FILE    = 4'h5;
    localparam logic [RUNG_W-1:0] FIRST_RUNG    = 10'h000;
    localparam logic [WORD_W-1:0] IN0_VALID_16  = 16'h03FF;
    localparam logic [WORD_W-1:0] IN0_VALID_32  = 16'hFFFF;
    localparam logic [WORD_W-1:0] IN1_VALID_32  = 16'h000F;
    localparam logic [WORD_W-1:0] OUT_VALID_16  = 16'h003F;
    localparam logic [WORD_W-1:0] OUT_VALID_32  = 16'h0FFF;
    localparam logic [WORD_W-1:0] WORD_ZERO     = 16'h0000;
    localparam logic [NEST_W-1:0] NEST_ZERO     = 4'h0;
    localparam logic [NEST_W-1:0] NEST_ONE      = 4'h1;
endpackage

// [dv/lfio_field_model.sv]
/*
 Field side of the executor: input sensors and output actuators.
 Assumes the bench sets sensor patterns; actuators are only observed.
*/
`timescale 1ns/1ns
module lfio_field_model
    import lfio_pkg::*;
(
    input  wire logic                        clk_sys,
    input  wire logic                        bigUnit,
    input  wire logic [lfio_pkg::WORD_W-1:0] sensorPat0,
    input  wire logic [lfio_pkg::WORD_W-1:0] sensorPat1,
    input  wire logic [lfio_pkg::WORD_W-1:0] actuatorWord,
    output logic      [lfio_pkg::WORD_W-1:0] firstInputWord,
    output logic      [lfio_pkg::WORD_W-1:0] secondInputWord,
    output logic      [lfio_pkg::WORD_W-1:0] actuators
);
    logic [WORD_W-1:0] noise = 16'h5A5A;
    logic [WORD_W-1:0] ok0, ok1;
    // ==========================================
    // Absent terminals toggle, so a stale bit can never pass as valid
    always @(posedge clk_sys) noise <= ~noise;
    assign ok0 = bigUnit ? IN0_VALID_32 : IN0_VALID_16;
    assign ok1 = bigUnit ? IN1_VALID_32 : WORD_ZERO;
    assign firstInputWord = (sensorPat0 & ok0) | (noise & ~ok0);
    assign secondInputWord = (sensorPat1 & ok1) | (noise & ~ok1);
    assign actuators = actuatorWord &
        (bigUnit ? OUT_VALID_32 : OUT_VALID_16);
endmodule

// [dv/tb_top.sv]
/*
 Self-checking bench for the program-flow and immediate I/O executor.
 Assumes the field model stands in for sensors and actuators.
*/
`timescale 1ns/1ns
module tb_top;
    import lfio_pkg::*;
    logic clk_sys, rst, bigUnit, opValid, rungTrue, opSelSecond, ioUpdateDone;
    lfio_op_t          opCode;
    logic [WORD_W-1:0] opMask, opSuspendId, pat0, pat1, in0, in1;
    logic [WORD_W-1:0] img0, img1, outImg, outWord, code, act;
    logic [FILE_W-1:0] curFile, rsFile;
    logic [RUNG_W-1:0] rsRung;
    logic [NEST_W-1:0] nest;
    logic              zoneInh, tmrRun, scanRs, ioReq, susp, flt;
    int                failures, total_checks, cycles;
    lfio_executor i_lfio_executor (.clk_sys(clk_sys), .rst(rst),
        .bigUnit(bigUnit), .opValid(opValid), .opCode(opCode),
        .rungTrue(rungTrue), .opSelSecond(opSelSecond), .opMask(opMask),
        .opSuspendId(opSuspendId), .opBitSel(opMask), .curFile(curFile),
        .ioUpdateDone(ioUpdateDone), .firstInputWord(in0),
        .secondInputWord(in1), .inImage0_r(img0), .inImage1_r(img1),
        .outImage_r(outImg), .firstOutputWord_r(outWord),
        .suspendCodeWord_r(code), .zoneInhibit_r(zoneInh),
        .timerRun_r(tmrRun), .scanRestart_r(scanRs), .restartFile_r(rsFile),
        .restartRung_r(rsRung), .ioUpdateReq_r(ioReq), .suspended_r(susp),
        .fault_r(flt), .nestDepth_r(nest));
    lfio_field_model i_lfio_field_model (.clk_sys(clk_sys),
        .bigUnit(bigUnit), .sensorPat0(pat0), .sensorPat1(pat1),
        .actuatorWord(outWord), .firstInputWord(in0),
        .secondInputWord(in1), .actuators(act));
    // ==========================================
    // Shared drivers and comparison
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic doReset(input logic big);
        @(negedge clk_sys);
        rst = 1;
        bigUnit = big;
        repeat (20) @(negedge clk_sys);
        rst = 0;
    endtask
    // One idle cycle between ops keeps each check on a settled value
    task automatic op(input lfio_op_t c, input logic r, input logic [15:0] m);
        @(negedge clk_sys);
        opValid = 1;
        opCode = c;
        rungTrue = r;
        opMask = m;
        @(negedge clk_sys);
        opValid = 0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic testIo;
        pat0 = 16'hA5C3;
        pat1 = 16'h00FA;
        op(LFIO_OP_IMM_IN, 1, 16'h0FF0);
        chk(img0, 16'h05C0);
        opSelSecond = 1;
        op(LFIO_OP_IMM_IN, 1, 16'hFFFF);
        opSelSecond = 0;
        chk(img1, 16'h000A);
        chk(img0, 16'h05C0);
        op(LFIO_OP_COIL, 1, 16'hFFFF);
        op(LFIO_OP_IMM_OUT, 1, 16'h00F0);
        chk(outWord, 16'h00F0);
        chk(act, 16'h00F0);
        op(LFIO_OP_IMM_OUT, 1, 16'hFFFF);
        chk(outWord, 16'h0FFF);
        $display("test io done");
    endtask
    // Zones are closed by an unconditional rung and never nested
    task automatic testZone;
        op(LFIO_OP_ZONE, 0, 16'h0000);
        chk(zoneInh, 1);
        op(LFIO_OP_COIL, 1, 16'h0001);
        chk(outImg, 16'hFFFE);
        op(LFIO_OP_TIMER, 1, 16'h0000);
        chk(tmrRun, 0);
        op(LFIO_OP_ZONE, 1, 16'h0000);
        chk(zoneInh, 0);
        op(LFIO_OP_ZONE, 1, 16'h0000);
        op(LFIO_OP_COIL, 1, 16'h0001);
        chk(outImg, 16'hFFFF);
        op(LFIO_OP_TIMER, 1, 16'h0000);
        chk(tmrRun, 1);
        op(LFIO_OP_COIL, 0, 16'h0002);
        chk(outImg, 16'hFFFD);
        op(LFIO_OP_ZONE, 1, 16'h0000);
        op(LFIO_OP_ZONE, 0, 16'h0000);
        op(LFIO_OP_JUMP_IN, 1, 16'h0000);
        op(LFIO_OP_COIL, 1, 16'h0002);
        chk(outImg, 16'hFFFF);
        chk(zoneInh, 0);
        op(LFIO_OP_ZONE, 1, 16'h0000);
        $display("test zone done");
    endtask
    task automatic testEnd;
        op(LFIO_OP_CALL, 1, 16'h0000);
        op(LFIO_OP_CALL, 1, 16'h0000);
        chk(nest, 2);
        op(LFIO_OP_RETURN, 1, 16'h0000);
        chk(nest, 1);
        op(LFIO_OP_CALL, 1, 16'h0000);
        op(LFIO_OP_TMP_END, 0, 16'h0000);
        chk(ioReq, 0);
        op(LFIO_OP_TMP_END, 1, 16'h0000);
        chk(ioReq, 1);
        chk(nest, 0);
        ioUpdateDone = 1;
        @(negedge clk_sys);
        ioUpdateDone = 0;
        chk(scanRs, 1);
        chk(rsFile, 2);
        chk(rsRung, 0);
        chk(img0, 16'hA5C3);
        chk(outWord, 16'h0FFF);
        @(negedge clk_sys);
        chk(scanRs, 0);
        op(LFIO_OP_FINAL_END, 0, 16'h0000);
        chk(ioReq, 1);
        ioUpdateDone = 1;
        @(negedge clk_sys);
        ioUpdateDone = 0;
        chk(scanRs, 1);
        opSuspendId = 16'h8000;
        op(LFIO_OP_SUSPEND, 1, 16'h0000);
        chk(susp, 1);
        chk(code, 16'h8000);
        chk(outWord, 16'h0000);
        for (int f = 3; f <= 5; f++) begin
            doReset(1);
            curFile = f[FILE_W-1:0];
            op(LFIO_OP_TMP_END, 1, 16'h0000);
            chk(flt, 1);
        end
        curFile = MAIN_FILE;
        $display("test end done");
    endtask
    task automatic testSmall;
        doReset(0);
        pat0 = 16'hFFFF;
        pat1 = 16'hFFFF;
        op(LFIO_OP_IMM_IN, 1, 16'hFFFF);
        chk(img0, 16'h03FF);
        opSelSecond = 1;
        op(LFIO_OP_IMM_IN, 1, 16'hFFFF);
        opSelSecond = 0;
        chk(img1, 16'h0000);
        op(LFIO_OP_COIL, 1, 16'hFFFF);
        op(LFIO_OP_IMM_OUT, 1, 16'hFFFF);
        chk(outWord, 16'h003F);
        chk(act, 16'h003F);
        $display("test small done");
    endtask
    // ==========================================
    // Clock, watchdog and main sequence
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        {rst, bigUnit} = 2'b11;
        {opValid, rungTrue, opSelSecond, ioUpdateDone} = 4'h0;
        opCode = LFIO_OP_NOP;
        {opMask, opSuspendId, pat0, pat1} = '0;
        curFile = MAIN_FILE;
        repeat (20) @(negedge clk_sys);
        rst = 0;
        testIo();
        testZone();
        testEnd();
        testSmall();
        complete_run();
    end
endmodule
